// ===== src/ubmtc_consts.vh
// Field positions and encodings for the channel baud, timer and trigger logic
`ifndef UBMTC_CONSTS_VH
`define UBMTC_CONSTS_VH

// Baud generator configuration fields
`define UBMTC_FRAC_MSB        3
`define UBMTC_FRAC_LSB        0
`define UBMTC_RATE_MSB        5
`define UBMTC_RATE_LSB        4
`define UBMTC_RATE_STD        2'h0
`define UBMTC_RATE_2X         2'h1
`define UBMTC_RATE_4X         2'h2
`define UBMTC_OVS_STD         4'hF
`define UBMTC_OVS_2X          4'h7
`define UBMTC_OVS_4X          4'h3

// First mode register fields
`define UBMTC_M1_TX_HALT      1
`define UBMTC_M1_AUTO_DIR     4

// Second mode register fields
`define UBMTC_M2_SPECIAL_EN   4
`define UBMTC_M2_MULTIDROP    6

// Flow configuration and stop character fields
`define UBMTC_FLOW_PIN_ADDR   2
`define UBMTC_ADDR_HI_MSB     7
`define UBMTC_ADDR_HI_LSB     4

// Half-duplex delay fields, counted in line bit periods
`define UBMTC_SETUP_MSB       7
`define UBMTC_SETUP_LSB       4
`define UBMTC_HOLD_MSB        3
`define UBMTC_HOLD_LSB        0

// Timer: enable bit and upper divisor bits in the high register
`define UBMTC_TMR_EN          7
`define UBMTC_TMR_HI_MSB      6
`define UBMTC_TMR_HALF_SHIFT  9

// Transmit sync configuration fields
`define UBMTC_TS_CMD_MSB      3
`define UBMTC_TS_CMD_LSB      0
`define UBMTC_TS_AUTO_OFF     4
`define UBMTC_TS_CLK_ROUTE    5
`define UBMTC_TS_SYNC_EN      7

// Trigger command values: fixed upper nibble, low nibble selects one of 16
`define UBMTC_TRIG_BASE       4'hE

// Pin layout: four pins per channel
`define UBMTC_PIN_CLK_OFS     0
`define UBMTC_PIN_TMR_OFS     1
`define UBMTC_PINS_PER_CH     4

`endif

// ===== src/ubmtc_top.v
// Per-channel baud generator, timer, multidrop filter, direction control and trigger logic
`timescale 1ns/1ps
`include "ubmtc_consts.vh"

module ubmtc_top #(
    parameter CHANNEL   = 0,
    parameter PIN_COUNT = 16
) (
    input  wire                 ref_clk_in,
    input  wire                 nrst_in,
    input  wire [7:0]           divisor_high_byte_in,
    input  wire [7:0]           divisor_low_byte_in,
    input  wire [7:0]           baud_gen_config_in,
    input  wire [7:0]           timer_divisor_low_in,
    input  wire [7:0]           timer_divisor_high_enable_in,
    input  wire [7:0]           transmit_sync_config_in,
    input  wire [7:0]           mode_control_one_in,
    input  wire [7:0]           mode_control_two_in,
    input  wire [7:0]           flow_config_in,
    input  wire [7:0]           second_stop_char_reg_in,
    input  wire [7:0]           half_duplex_delay_in,
    input  wire                 ir_request_in,
    input  wire [3:0]           addr_pins_in,
    input  wire                 rx_word_valid_in,
    input  wire [7:0]           rx_word_in,
    input  wire                 rx_ninth_bit_in,
    input  wire                 address_flag_clear_in,
    input  wire                 tx_fifo_has_data_in,
    input  wire                 tx_busy_in,
    input  wire                 global_cmd_write_in,
    input  wire [7:0]           global_command_reg_in,
    input  wire [7:0]           trigger_delay_low_in,
    input  wire [7:0]           trigger_delay_high_in,
    output reg                  baud_tick_out,
    output reg                  bit_tick_out,
    output wire                 rx_single_sample_out,
    output wire                 ir_coding_en_out,
    output wire                 parity_check_en_out,
    output reg                  address_received_flag_out,
    output reg                  rx_store_valid_out,
    output reg  [7:0]           rx_store_data_out,
    output reg                  rts_out,
    output wire                 tx_start_out,
    output wire                 tx_enabled_out,
    output wire [PIN_COUNT-1:0] gpio_drive_out,
    output wire [PIN_COUNT-1:0] gpio_drive_en_n_out
);
    localparam DIR_IDLE  = 2'h0;
    localparam DIR_SETUP = 2'h1;
    localparam DIR_SEND  = 2'h2;
    localparam DIR_HOLD  = 2'h3;
    localparam integer PIN_CLK = CHANNEL * `UBMTC_PINS_PER_CH + `UBMTC_PIN_CLK_OFS;
    localparam integer PIN_TMR = CHANNEL * `UBMTC_PINS_PER_CH + `UBMTC_PIN_TMR_OFS;
    // Oversample limit for a rate mode; unused code falls back to standard
    function [3:0] ovs_limit;
        input [1:0] mode;
        begin
            case (mode)
                `UBMTC_RATE_2X: ovs_limit = `UBMTC_OVS_2X;
                `UBMTC_RATE_4X: ovs_limit = `UBMTC_OVS_4X;
                default:        ovs_limit = `UBMTC_OVS_STD;
            endcase
        end
    endfunction
    wire [1:0]  rate_mode = baud_gen_config_in[`UBMTC_RATE_MSB:`UBMTC_RATE_LSB];
    wire [3:0]  frac_div  = baud_gen_config_in[`UBMTC_FRAC_MSB:`UBMTC_FRAC_LSB];
    wire [15:0] int_div   = {divisor_high_byte_in, divisor_low_byte_in};

    // ---------------- Fractional baud generator ----------------
    reg  [15:0] brg_cnt_reg;
    reg  [15:0] brg_cnt_next;
    reg  [3:0]  frac_acc_reg;
    reg  [3:0]  frac_acc_next;
    reg         stretch_reg;
    reg         stretch_next;
    reg  [3:0]  ovs_cnt_reg;
    reg  [3:0]  ovs_cnt_next;
    wire [4:0]  frac_sum  = {1'b0, frac_acc_reg} + {1'b0, frac_div};
    wire [16:0] brg_limit = {1'b0, int_div} + {16'h0000, stretch_reg};
    wire        brg_end   = ({1'b0, brg_cnt_reg} + 17'h00001) >= brg_limit;

    always @* begin
        brg_cnt_next  = brg_cnt_reg + 16'h0001;
        frac_acc_next = frac_acc_reg;
        stretch_next  = stretch_reg;
        ovs_cnt_next  = ovs_cnt_reg;
        if (brg_end) begin
            brg_cnt_next  = 16'h0000;
            frac_acc_next = frac_sum[3:0];
            stretch_next  = frac_sum[4];
            if (ovs_cnt_reg >= ovs_limit(rate_mode))
                ovs_cnt_next = 4'h0;
            else
                ovs_cnt_next = ovs_cnt_reg + 4'h1;
        end
    end

    always @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            brg_cnt_reg   <= 16'h0000;
            frac_acc_reg  <= 4'h0;
            stretch_reg   <= 1'b0;
            ovs_cnt_reg   <= 4'h0;
            baud_tick_out <= 1'b0;
            bit_tick_out  <= 1'b0;
        end else begin
            brg_cnt_reg   <= brg_cnt_next;
            frac_acc_reg  <= frac_acc_next;
            stretch_reg   <= stretch_next;
            ovs_cnt_reg   <= ovs_cnt_next;
            baud_tick_out <= brg_end;
            bit_tick_out  <= brg_end && (ovs_cnt_reg >= ovs_limit(rate_mode));
        end
    end

    assign rx_single_sample_out = (rate_mode == `UBMTC_RATE_4X);
    assign ir_coding_en_out = ir_request_in && (rate_mode != `UBMTC_RATE_2X)
                              && (rate_mode != `UBMTC_RATE_4X);
    // ---------------- Low-frequency timer ----------------
    wire [14:0] tmr_div  = {timer_divisor_high_enable_in[`UBMTC_TMR_HI_MSB:0],
                            timer_divisor_low_in};
    wire        tmr_en   = timer_divisor_high_enable_in[`UBMTC_TMR_EN];
    wire [23:0] tmr_half = {9'h000, tmr_div} << `UBMTC_TMR_HALF_SHIFT;
    reg  [23:0] tmr_cnt_reg;
    reg         tmr_clk_reg;

    always @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            tmr_cnt_reg <= 24'h000000;
            tmr_clk_reg <= 1'b0;
        end else if (!tmr_en || tmr_div == 15'h0000) begin
            tmr_cnt_reg <= 24'h000000;
            tmr_clk_reg <= 1'b0;
        end else if (brg_end) begin
            if (tmr_cnt_reg + 24'h000001 >= tmr_half) begin
                tmr_cnt_reg <= 24'h000000;
                tmr_clk_reg <= ~tmr_clk_reg;
            end else begin
                tmr_cnt_reg <= tmr_cnt_reg + 24'h000001;
            end
        end
    end

    // Reference clock leaves through a gate, not a flop, to keep its full rate
    wire clk_route_en = transmit_sync_config_in[`UBMTC_TS_CLK_ROUTE];

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
            if (gi == PIN_CLK) begin : g_clk
                assign gpio_drive_out[gi]      = ref_clk_in & clk_route_en;
                assign gpio_drive_en_n_out[gi] = ~clk_route_en;
            end else if (gi == PIN_TMR) begin : g_tmr
                assign gpio_drive_out[gi]      = tmr_clk_reg;
                assign gpio_drive_en_n_out[gi] = ~tmr_en;
            end else begin : g_off
                assign gpio_drive_out[gi]      = 1'b0;
                assign gpio_drive_en_n_out[gi] = 1'b1;
            end
        end
    endgenerate

    // ---------------- Multidrop address detection and filtering ----------------
    reg  [3:0] pins_meta_reg;
    reg  [3:0] pins_sync_reg;
    reg        addr_match_reg;
    wire       multidrop = mode_control_two_in[`UBMTC_M2_MULTIDROP];
    wire       filter_en = multidrop && mode_control_two_in[`UBMTC_M2_SPECIAL_EN];
    wire [7:0] station_addr = flow_config_in[`UBMTC_FLOW_PIN_ADDR] ?
        {second_stop_char_reg_in[`UBMTC_ADDR_HI_MSB:`UBMTC_ADDR_HI_LSB], pins_sync_reg} :
        second_stop_char_reg_in;
    wire       addr_word = multidrop && rx_ninth_bit_in;

    assign parity_check_en_out = ~multidrop;

    always @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            pins_meta_reg             <= 4'h0;
            pins_sync_reg             <= 4'h0;
            addr_match_reg            <= 1'b0;
            address_received_flag_out <= 1'b0;
            rx_store_valid_out        <= 1'b0;
            rx_store_data_out         <= 8'h00;
        end else begin
            pins_meta_reg <= addr_pins_in;
            pins_sync_reg <= pins_meta_reg;
            if (rx_word_valid_in && addr_word)
                address_received_flag_out <= 1'b1;
            else if (address_flag_clear_in)
                address_received_flag_out <= 1'b0;
            if (rx_word_valid_in && addr_word)
                addr_match_reg <= (rx_word_in == station_addr);
            rx_store_valid_out <= rx_word_valid_in &&
                                  (!filter_en || (!addr_word && addr_match_reg));
            if (rx_word_valid_in)
                rx_store_data_out <= rx_word_in;
        end
    end

    // ---------------- Transmitter enable, trigger and auto-off ----------------
    wire       tx_halt   = mode_control_one_in[`UBMTC_M1_TX_HALT];
    wire       auto_off  = transmit_sync_config_in[`UBMTC_TS_AUTO_OFF];
    wire       sync_en   = transmit_sync_config_in[`UBMTC_TS_SYNC_EN];
    wire [7:0] trig_code = {`UBMTC_TRIG_BASE,
                            transmit_sync_config_in[`UBMTC_TS_CMD_MSB:`UBMTC_TS_CMD_LSB]};
    reg        halt_prev_reg;
    reg        auto_off_reg;
    reg        triggered_reg;
    reg        trig_wait_reg;
    reg        sent_reg;
    reg [15:0] trig_cnt_reg;
    wire       halt_toggle = tx_halt ^ halt_prev_reg;
    wire       tx_enabled  = triggered_reg || (!tx_halt && !auto_off_reg);
    wire       trig_hit    = global_cmd_write_in && sync_en &&
                             (global_command_reg_in == trig_code);
    wire       trig_fire   = trig_hit && !tx_enabled && tx_fifo_has_data_in && !trig_wait_reg;
    wire       drained     = sent_reg && !tx_fifo_has_data_in && !tx_busy_in;
    assign tx_enabled_out = tx_enabled;
    always @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            halt_prev_reg <= 1'b0;
            auto_off_reg  <= 1'b0;
            triggered_reg <= 1'b0;
            trig_wait_reg <= 1'b0;
            sent_reg      <= 1'b0;
            trig_cnt_reg  <= 16'h0000;
        end else begin
            halt_prev_reg <= tx_halt;
            if (tx_busy_in)
                sent_reg <= 1'b1;
            else if (drained)
                sent_reg <= 1'b0;
            if (auto_off && drained)
                auto_off_reg <= 1'b1;
            else if (!auto_off || halt_toggle)
                auto_off_reg <= 1'b0;
            if (trig_fire) begin
                trig_wait_reg <= 1'b1;
                trig_cnt_reg  <= {trigger_delay_high_in, trigger_delay_low_in};
            end else if (trig_wait_reg) begin
                if (trig_cnt_reg == 16'h0000) begin
                    trig_wait_reg <= 1'b0;
                    triggered_reg <= 1'b1;
                end else if (brg_end) begin
                    trig_cnt_reg <= trig_cnt_reg - 16'h0001;
                end
            end else if ((auto_off && drained) || halt_toggle) begin
                triggered_reg <= 1'b0;
            end
        end
    end

    // ---------------- Auto transceiver direction control ----------------
    reg [1:0] dir_state_reg;
    reg [1:0] dir_state_next;
    reg [3:0] dir_cnt_reg;
    reg [3:0] dir_cnt_next;
    wire      auto_dir  = mode_control_one_in[`UBMTC_M1_AUTO_DIR];
    wire [3:0] setup_bits = half_duplex_delay_in[`UBMTC_SETUP_MSB:`UBMTC_SETUP_LSB];
    wire [3:0] hold_bits  = half_duplex_delay_in[`UBMTC_HOLD_MSB:`UBMTC_HOLD_LSB];
    wire      want_send = tx_enabled && tx_fifo_has_data_in;

    always @* begin
        dir_state_next = dir_state_reg;
        dir_cnt_next   = dir_cnt_reg;
        case (dir_state_reg)
            DIR_IDLE: begin
                if (auto_dir && want_send) begin
                    dir_state_next = (setup_bits == 4'h0) ? DIR_SEND : DIR_SETUP;
                    dir_cnt_next   = setup_bits;
                end
            end
            DIR_SETUP: begin
                if (bit_tick_out) begin
                    dir_cnt_next = dir_cnt_reg - 4'h1;
                    if (dir_cnt_reg == 4'h1)
                        dir_state_next = DIR_SEND;
                end
            end
            DIR_SEND: begin
                if (!tx_busy_in && !want_send) begin
                    dir_state_next = (hold_bits == 4'h0) ? DIR_IDLE : DIR_HOLD;
                    dir_cnt_next   = hold_bits;
                end
            end
            DIR_HOLD: begin
                if (want_send) begin
                    dir_state_next = DIR_SEND;
                end else if (bit_tick_out) begin
                    dir_cnt_next = dir_cnt_reg - 4'h1;
                    if (dir_cnt_reg == 4'h1)
                        dir_state_next = DIR_IDLE;
                end
            end
            default: begin
                dir_state_next = DIR_IDLE;
            end
        endcase
        if (!auto_dir)
            dir_state_next = DIR_IDLE;
    end

    always @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            dir_state_reg <= DIR_IDLE;
            dir_cnt_reg   <= 4'h0;
            rts_out       <= 1'b0;
        end else begin
            dir_state_reg <= dir_state_next;
            dir_cnt_reg   <= dir_cnt_next;
            rts_out       <= (dir_state_next != DIR_IDLE);
        end
    end

    // Without auto direction the transmitter starts as soon as it may
    assign tx_start_out = want_send && (!auto_dir || dir_state_reg == DIR_SEND);

endmodule // ubmtc_top

// ===== testbench/ubmtc_chk.sv
// Port assertions for the channel baud, timer, multidrop and trigger block
`timescale 1ns/1ps
`include "ubmtc_consts.vh"
module ubmtc_chk #(
    parameter CHANNEL   = 0,
    parameter PIN_COUNT = 16
) (
    input logic                 ref_clk_in,
    input logic                 nrst_in,
    input logic [7:0]           baud_gen_config_in,
    input logic [7:0]           timer_divisor_high_enable_in,
    input logic [7:0]           transmit_sync_config_in,
    input logic [7:0]           mode_control_one_in,
    input logic [7:0]           mode_control_two_in,
    input logic                 rx_word_valid_in,
    input logic                 rx_ninth_bit_in,
    input logic                 address_flag_clear_in,
    input logic                 tx_fifo_has_data_in,
    input logic                 tx_busy_in,
    input logic                 rx_single_sample_out,
    input logic                 ir_coding_en_out,
    input logic                 parity_check_en_out,
    input logic                 address_received_flag_out,
    input logic                 rx_store_valid_out,
    input logic                 rts_out,
    input logic                 tx_start_out,
    input logic                 tx_enabled_out,
    input logic [PIN_COUNT-1:0] gpio_drive_en_n_out
);
    localparam TPIN = CHANNEL * `UBMTC_PINS_PER_CH + `UBMTC_PIN_TMR_OFS;
    localparam CPIN = CHANNEL * `UBMTC_PINS_PER_CH + `UBMTC_PIN_CLK_OFS;
    wire [1:0] rate  = baud_gen_config_in[`UBMTC_RATE_MSB:`UBMTC_RATE_LSB];
    wire       mdrop = mode_control_two_in[`UBMTC_M2_MULTIDROP];
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    ir_off_fast_a: assert property ((rate == `UBMTC_RATE_2X || rate == `UBMTC_RATE_4X)
        [*3] |-> !ir_coding_en_out)
        else $error("infrared coding active in a fast rate mode");
    single_sample_a: assert property ((rate == `UBMTC_RATE_4X)[*3] |-> rx_single_sample_out)
        else $error("single mid-bit sample missing in quadruple rate");
    parity_off_a: assert property (mdrop[*3] |-> !parity_check_en_out)
        else $error("parity check left on in multidrop mode");
    addr_flag_a: assert property (rx_word_valid_in && rx_ninth_bit_in && mdrop
        && !address_flag_clear_in |-> ##[0:3] address_received_flag_out)
        else $error("address flag not raised by address word");
    addr_not_stored_a: assert property (rx_word_valid_in && rx_ninth_bit_in && mdrop
        && mode_control_two_in[`UBMTC_M2_SPECIAL_EN] |=> !rx_store_valid_out)
        else $error("address word stored in filtering mode");
    store_cause_a: assert property (rx_store_valid_out |-> rx_word_valid_in
        || $past(rx_word_valid_in) || $past(rx_word_valid_in, 2))
        else $error("store without a received word");
    start_data_a: assert property (tx_start_out
        |-> tx_fifo_has_data_in && tx_enabled_out)
        else $error("transmit start while disabled or with empty fifo");
    rts_busy_a: assert property ((mode_control_one_in[`UBMTC_M1_AUTO_DIR]
        && tx_busy_in)[*2] |-> rts_out)
        else $error("request-to-send low while sending");
    tmr_pin_a: assert property (timer_divisor_high_enable_in[`UBMTC_TMR_EN][*3]
        |-> !gpio_drive_en_n_out[TPIN])
        else $error("timer pin not driven when enabled");
    clk_pin_a: assert property (transmit_sync_config_in[`UBMTC_TS_CLK_ROUTE][*3]
        |-> !gpio_drive_en_n_out[CPIN])
        else $error("clock pin not driven when routed");
endmodule // ubmtc_chk
bind ubmtc_top ubmtc_chk #(.CHANNEL(CHANNEL), .PIN_COUNT(PIN_COUNT)) u_chk (.*);

// ===== testbench/ubmtc_partner.sv
// Transmit fifo and sender stand-in on the far side of the start control
`timescale 1ns/1ps
module ubmtc_partner #(
    parameter WORD_CYCLES = 20
) (
    input  logic ref_clk_in,
    input  logic nrst_in,
    input  logic load_in,
    input  logic tx_start_in,
    output logic has_data_out,
    output logic busy_out
);
    int   level_reg;
    int   cnt_reg;
    logic act_reg;
    assign has_data_out = level_reg != 0;
    assign busy_out     = act_reg;
    always @(posedge ref_clk_in) begin
        if (!nrst_in) begin
            level_reg <= 0;
            cnt_reg   <= 0;
            act_reg   <= 1'b0;
        end else if ((act_reg || tx_start_in) && cnt_reg == 0 && level_reg != 0) begin
            act_reg   <= 1'b1;
            cnt_reg   <= WORD_CYCLES;
            level_reg <= level_reg - 1 + load_in;
        end else begin
            level_reg <= level_reg + load_in;
            if (cnt_reg != 0)
                cnt_reg <= cnt_reg - 1;
            else
                act_reg <= 1'b0;
        end
    end
endmodule // ubmtc_partner

// ===== testbench/testbench.sv
// Self-checking bench for the channel support block
`timescale 1ns/1ps
`include "ubmtc_consts.vh"
module testbench;
    localparam TPIN = `UBMTC_PIN_TMR_OFS;
    localparam CPIN = `UBMTC_PIN_CLK_OFS;
    logic ref_clk_in, nrst_in, ir_request_in, rx_word_valid_in, rx_ninth_bit_in;
    logic address_flag_clear_in, tx_fifo_has_data_in, tx_busy_in, global_cmd_write_in;
    logic [7:0] divisor_high_byte_in, divisor_low_byte_in, baud_gen_config_in;
    logic [7:0] timer_divisor_low_in, timer_divisor_high_enable_in, transmit_sync_config_in;
    logic [7:0] mode_control_one_in, mode_control_two_in, flow_config_in, rx_word_in;
    logic [7:0] second_stop_char_reg_in, half_duplex_delay_in, global_command_reg_in;
    logic [7:0] trigger_delay_low_in, trigger_delay_high_in;
    logic [3:0] addr_pins_in;
    logic baud_tick_out, bit_tick_out, rx_single_sample_out, ir_coding_en_out;
    logic parity_check_en_out, address_received_flag_out, rx_store_valid_out, rts_out;
    logic tx_start_out, tx_enabled_out, load_word, sel, st_prev;
    logic [7:0] rx_store_data_out, st_addr;
    logic [15:0] gpio_drive_out, gpio_drive_en_n_out;
    logic [31:0] rnd;
    logic [7:0] exp_q[$], got_q[$];
    int n_errors, num_checks, n_starts, c, sum, s, dv, fr, k, i;
    int hi[4] = '{0, 0, 0, 1};
    int md[4] = '{0, 1, 2, 2};
    int ovs[4] = '{16, 8, 4, 4};
    ubmtc_top #(.CHANNEL(0), .PIN_COUNT(16)) dut (.*);
    ubmtc_partner #(.WORD_CYCLES(20)) partner (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .load_in(load_word), .tx_start_in(tx_start_out), .has_data_out(tx_fifo_has_data_in),
        .busy_out(tx_busy_in));
    initial begin
        ref_clk_in = 0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        if (rx_store_valid_out === 1'b1) got_q.push_back(rx_store_data_out);
        if (tx_start_out === 1'b1 && !st_prev) n_starts++;
        st_prev = tx_start_out === 1'b1;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic end_of_test();
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    // Waits for a baud tick, a bit tick or a timer pin edge, bounded
    task automatic wait_ev(input int ev, output int cyc);
        logic p;
        p = gpio_drive_out[TPIN];
        cyc = 0;
        do begin
            tick(1);
            cyc++;
            if (cyc > 20000) begin
                n_errors++;
                end_of_test();
            end
        end while (!(ev == 0 ? baud_tick_out === 1'b1 : ev == 1 ? bit_tick_out === 1'b1
                     : gpio_drive_out[TPIN] !== p));
    endtask
    task automatic send_word(input logic nine, input logic [7:0] w);
        rx_word_in = w;
        rx_ninth_bit_in = nine;
        rx_word_valid_in = 1;
        tick(1);
        rx_word_valid_in = 0;
        if (nine) sel = w == st_addr;
        else if (sel) exp_q.push_back(w);
        tick(7);
        if (nine) cmp("addr_flag", 1, address_received_flag_out);
    endtask
    task automatic send_data(input int n);
        repeat (n) begin
            rnd = lfsr(rnd);
            send_word(0, rnd[7:0]);
        end
    endtask
    task automatic gcmd(input logic [7:0] v, input int e);
        s = n_starts;
        global_command_reg_in = v;
        global_cmd_write_in = 1;
        tick(1);
        global_cmd_write_in = 0;
        tick(7);
        cmp("trig_delay", 0, rts_out);
        tick(57);
        cmp("trig_start", e, n_starts - s);
    endtask
    initial begin
        {nrst_in, rx_word_valid_in, rx_ninth_bit_in, address_flag_clear_in, load_word} = 0;
        {global_cmd_write_in, divisor_high_byte_in, baud_gen_config_in, rx_word_in} = 0;
        {timer_divisor_low_in, timer_divisor_high_enable_in, transmit_sync_config_in} = 0;
        {mode_control_one_in, mode_control_two_in, flow_config_in, addr_pins_in} = 0;
        {second_stop_char_reg_in, half_duplex_delay_in, global_command_reg_in} = 0;
        {trigger_delay_low_in, trigger_delay_high_in} = 0;
        {n_errors, num_checks, n_starts, st_prev, sel, st_addr} = 0;
        divisor_low_byte_in = 8'h01;
        ir_request_in = 1;
        rnd = 32'hD380;
        repeat (20) @(posedge ref_clk_in);
        #1 nrst_in = 1;
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            dv = 1 + rnd[2:0] % 6;
            fr = rnd[7:4];
            divisor_high_byte_in = hi[i];
            divisor_low_byte_in = dv;
            baud_gen_config_in = {2'h0, md[i][1:0], rnd[7:4]};
            dv += 256 * hi[i];
            tick(40);
            cmp("single_sample", md[i] == 2, rx_single_sample_out);
            wait_ev(0, c);
            sum = 0;
            repeat (16) begin wait_ev(0, c); sum += c; end
            cmp("baud_span", 16 * dv + fr, sum);
            wait_ev(1, c);
            sum = 0;
            repeat (16) begin wait_ev(1, c); sum += c; end
            cmp("bit_span", ovs[i] * (16 * dv + fr), sum);
        end
        divisor_high_byte_in = 0;
        divisor_low_byte_in = 2;
        baud_gen_config_in = 0;
        rnd = lfsr(rnd);
        timer_divisor_low_in = 1 + rnd[1:0];
        timer_divisor_high_enable_in = 8'h80;
        tick(4);
        cmp("tmr_pin_en", 0, gpio_drive_en_n_out[TPIN]);
        wait_ev(2, c);
        for (i = 0; i < 2; i++) begin
            wait_ev(2, c);
            cmp("tmr_half", 1024 * timer_divisor_low_in, c);
        end
        transmit_sync_config_in = 8'h20;
        tick(4);
        cmp("clk_pin_en", 0, gpio_drive_en_n_out[CPIN]);
        mode_control_two_in = 8'h50;
        second_stop_char_reg_in = 8'hA5;
        st_addr = 8'hA5;
        send_word(1, 8'hA5);
        send_data(3);
        send_word(1, 8'h3C);
        send_data(2);
        address_flag_clear_in = 1;
        tick(1);
        address_flag_clear_in = 0;
        tick(3);
        cmp("addr_flag_clr", 0, address_received_flag_out);
        flow_config_in = 8'h04;
        addr_pins_in = 4'h9;
        tick(2);
        st_addr = 8'hA9;
        send_word(1, 8'hA9);
        send_data(2);
        addr_pins_in = 4'h2;
        tick(2);
        st_addr = 8'hA2;
        send_word(1, 8'hA9);
        send_data(2);
        send_word(1, 8'hA2);
        send_data(2);
        cmp("store_count", exp_q.size(), got_q.size());
        foreach (exp_q[k]) cmp("store_data", exp_q[k], got_q[k]);
        mode_control_one_in = 8'h12;
        half_duplex_delay_in = 8'h11;
        for (k = 0; k < 16; k++) begin
            transmit_sync_config_in = 8'h90 | k;
            trigger_delay_low_in = 4 + k[1:0];
            load_word = k != 0;
            tick(2);
            load_word = 0;
            gcmd({`UBMTC_TRIG_BASE, k[3:0] ^ 4'h1}, 0);
            gcmd({`UBMTC_TRIG_BASE, k[3:0]}, k != 0);
            tick(200);
        end
        end_of_test();
    end
endmodule // testbench
